// *** core/pgbl_core.sv ***
// Overview of operation
// - each Bayer colour keeps its own gain and analog offset settings
// - signed digital offset -512..511 added after digital gain, 12-bit out
// - digital gain is one plus code over eight
// - analog gain is (1 + doubler) times code over eight
// - overall gain is analog gain times digital gain, 0 to about 265.8
// - analog calibration samples then adjusts, per colour, own method each
// - offsets steered so dark-row mean lies inside target thresholds
// - big correction only after reset or analog gain change
// - green lock with equal gains gives first green offset to both
// - red-blue lock with equal gains gives red offset to both
// - reading an offset register returns the offset in effect
// - fixed mode writes act at once, else held until fixed entry
// - fixed mode stops calibration sampling and adjustment; row black still measured
// - row black measured per colour from leading shielded pixels
// - row correction adds target minus measured row black to actives
// - correction off adds one shared default offset
module pgbl_core
	import pgbl_pkg::*;
(
	// clock, reset, enable
	input  wire logic             CORE_CLK,
	input  wire logic             NRST,
	input  wire logic             CE,
	// apb slave
	input  wire logic             PSEL,
	input  wire logic             PENABLE,
	input  wire logic             PWRITE,
	input  wire logic [11:0]      PADDR,
	input  wire logic [31:0]      PWDATA,
	output logic      [31:0]      PRDATA,
	output logic                  PREADY,
	output logic                  PSLVERR,
	// pixels from the array adc
	input  wire logic             PIX_VALID,
	input  wire logic [11:0]      PIX_DATA,
	input  wire logic             PIX_FRAME_START,
	input  wire logic             PIX_ROW_START,
	input  wire logic             PIX_DARK_ROW,
	input  wire logic             PIX_DARK_COL,
	// pixels to the host
	output logic      [11:0]      DOUT,
	output logic                  DOUT_VALID,
	// analog front end controls
	output logic      [3:0][6:0]  ANA_GAIN_X8,
	output logic      [3:0][8:0]  ANA_OFFSET
);
	////////////////////////////////////////////////////////////////////
	logic             cap_r, rbl_sel_r, err_r;
	logic [31:0]      prdata_r, rd_data;
	logic             rd_err, apb_wr, in_gain, in_aofs, in_rbl;
	logic             fixed_enter;
	logic [3:0]       ctrl_r;
	logic [11:0]      thr_lo_r, thr_hi_r, row_tgt_r;
	logic [9:0]       row_def_r, dig_ofs_r;
	logic [5:0]       code_r [4];
	logic             dbl_r [4];
	logic [6:0]       dig_r [4];
	logic [6:0]       agx8 [4];
	logic [14:0]      tot [4];
	logic [8:0]       aofs_r [4];
	logic [8:0]       pend_r [4];
	logic             pend_v_r [4];
	pgbl_blc_e        mode_r [4];
	logic [8:0]       eff [4];
	logic             gain_chg [4];
	logic             blc_evt [4];
	logic [11:0]      blc_avg [4];
	logic [3:0]       rbl_we;
	logic [3:0][11:0] rbl_wd;
	logic [11:0]      rbl_a, rbl_b;
	logic             row_par_r, col_par_r;
	logic             act1_r, dk1_r, drow1_r, rs1_r;
	logic             act2_r, dk2_r, rs2_r;
	logic [11:0]      pix1_r;
	pgbl_col_e        col1_r, col2_r;
	logic [19:0]      prod;
	logic [16:0]      g2_r;
	logic [13:0]      corr;
	logic [18:0]      sum;
	logic [11:0]      dout_r;
	logic             dvld_r;
	logic [5:0]       g_first_ana_gain_code, g_second_ana_gain_code;
	logic             g_first_ana_doubler, g_second_ana_doubler;
	logic             eq_g, eq_rb;

	////////////////////////////////////////////////////////////////////
	// apb: zero wait states once the setup cycle has been captured
	assign PREADY  = PSEL & PENABLE & cap_r & CE;
	assign PSLVERR = PREADY & err_r;
	assign PRDATA  = rbl_sel_r ? {20'h00000, rbl_b} : prdata_r;
	assign apb_wr  = PREADY & PWRITE;
	assign in_gain = PADDR[11:4] == OFS_GAIN[11:4] && PADDR[1:0] == 2'h0;
	assign in_aofs = PADDR[11:4] == OFS_AOFS[11:4] && PADDR[1:0] == 2'h0;
	assign in_rbl  = PADDR[11:4] == OFS_RBL[11:4] && PADDR[1:0] == 2'h0;
	assign fixed_enter = apb_wr && PADDR == OFS_CTRL &&
		PWDATA[CTRL_FIXED] && !ctrl_r[CTRL_FIXED];

	always_comb begin
		rd_data = 32'h00000000;
		rd_err  = 1'b0;
		case (PADDR)
			OFS_CTRL:    rd_data = {28'h0000000, ctrl_r};
			OFS_THR:     rd_data = {4'h0, thr_hi_r, 4'h0, thr_lo_r};
			OFS_ROW_TGT: rd_data = {20'h00000, row_tgt_r};
			OFS_ROW_DEF: rd_data = {22'h000000, row_def_r};
			OFS_DIG_OFS: rd_data = {22'h000000, dig_ofs_r};
			default: begin
				if (in_gain) begin
					rd_data = {1'b0, tot[PADDR[3:2]], 1'b0, dig_r[PADDR[3:2]],
						1'b0, dbl_r[PADDR[3:2]], code_r[PADDR[3:2]]};
				end else if (in_aofs) begin
					rd_data = {23'h000000, eff[PADDR[3:2]]};
				end else if (!in_rbl) begin
					rd_err = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			cap_r     <= 1'b0;
			prdata_r  <= 32'h00000000;
			rbl_sel_r <= 1'b0;
			err_r     <= 1'b0;
		end else if (CE) begin
			cap_r <= PSEL & ~(PENABLE & cap_r);
			if (PSEL && !cap_r) begin
				prdata_r  <= rd_data;
				rbl_sel_r <= in_rbl;
				err_r     <= rd_err;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			ctrl_r    <= CTRL_RST;
			thr_lo_r  <= THR_LO_RST;
			thr_hi_r  <= THR_HI_RST;
			row_tgt_r <= ROW_TGT_RST;
			row_def_r <= ROW_DEF_RST;
			dig_ofs_r <= DIG_OFS_RST;
		end else if (CE && apb_wr) begin
			case (PADDR)
				OFS_CTRL:    ctrl_r    <= PWDATA[3:0];
				OFS_THR: begin
					thr_lo_r <= PWDATA[11:0];
					thr_hi_r <= PWDATA[THR_HI_LSB +: 12];
				end
				OFS_ROW_TGT: row_tgt_r <= PWDATA[11:0];
				OFS_ROW_DEF: row_def_r <= PWDATA[9:0];
				OFS_DIG_OFS: dig_ofs_r <= PWDATA[9:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// offset locking on the shared signal chains
	assign g_first_ana_gain_code  = code_r[COL_G1];
	assign g_second_ana_gain_code = code_r[COL_G2];
	assign g_first_ana_doubler    = dbl_r[COL_G1];
	assign g_second_ana_doubler   = dbl_r[COL_G2];
	assign eq_g  = g_first_ana_gain_code == g_second_ana_gain_code &&
		g_first_ana_doubler == g_second_ana_doubler;
	assign eq_rb = code_r[COL_R] == code_r[COL_B] &&
		dbl_r[COL_R] == dbl_r[COL_B];
	assign eff[COL_G1] = aofs_r[COL_G1];
	assign eff[COL_R]  = aofs_r[COL_R];
	assign eff[COL_B]  = (ctrl_r[CTRL_LOCK_RB] && eq_rb) ?
		aofs_r[COL_R] : aofs_r[COL_B];
	assign eff[COL_G2] = (ctrl_r[CTRL_LOCK_G] && eq_g) ?
		aofs_r[COL_G1] : aofs_r[COL_G2];

	////////////////////////////////////////////////////////////////////
	// per-colour gain, analog calibration and row black measurement
	for (genvar c = 0; c < 4; c++) begin : g_col
		logic        hit, ofs_wr, take, dk_take, dfull_r;
		logic [15:0] bsum_r;
		logic [4:0]  bcnt_r;
		logic [19:0] dsum_r, dsum_nx;
		logic [2:0]  dcnt_r;
		logic [8:0]  step, up, dn;
		logic [9:0]  up_w;

		assign hit    = PADDR[3:2] == 2'(c);
		assign ofs_wr = apb_wr && in_aofs && hit;
		assign agx8[c] = dbl_r[c] ? {code_r[c], 1'b0}
			: {1'b0, code_r[c]};
		assign tot[c] = {8'h00, agx8[c]} *
			{7'h00, DIG_UNITY + {1'b0, dig_r[c]}};
		assign gain_chg[c] = apb_wr && in_gain && hit &&
			(PWDATA[5:0] != code_r[c] || PWDATA[GAIN_DBL_BIT] != dbl_r[c]);

		always_ff @(posedge CORE_CLK) begin
			if (!NRST) begin
				code_r[c] <= ANA_CODE_RST;
				dbl_r[c]  <= 1'b0;
				dig_r[c]  <= DIG_CODE_RST;
			end else if (CE && apb_wr && in_gain && hit) begin
				code_r[c] <= PWDATA[5:0];
				dbl_r[c]  <= PWDATA[GAIN_DBL_BIT];
				dig_r[c]  <= PWDATA[GAIN_DIG_LSB +: 7];
			end
		end

		// fixed mode takes no calibration samples; row black sampling carries on
		assign take = !ctrl_r[CTRL_FIXED] && act1_r && drow1_r &&
			col1_r == pgbl_col_e'(c) && bcnt_r != BLC_CNT_FULL;
		assign blc_evt[c] = PIX_FRAME_START && !ctrl_r[CTRL_FIXED] &&
			bcnt_r == BLC_CNT_FULL;
		assign blc_avg[c] = bsum_r[15:4];

		always_ff @(posedge CORE_CLK) begin
			if (!NRST) begin
				bsum_r <= 16'h0000;
				bcnt_r <= 5'h00;
			end else if (CE) begin
				if (PIX_FRAME_START) begin
					bsum_r <= 16'h0000;
					bcnt_r <= 5'h00;
				end else if (take) begin
					bsum_r <= bsum_r + {4'h0, pix1_r};
					bcnt_r <= bcnt_r + 5'h01;
				end
			end
		end

		// coarse steps from reset or an analog gain change until the level lands in the window
		assign step = (mode_r[c] == BLC_COARSE) ? STEP_COARSE
			: STEP_FINE;
		assign up_w = {1'b0, aofs_r[c]} + {1'b0, step};
		assign up   = up_w[9] ? AOFS_MAX : up_w[8:0];
		assign dn   = (aofs_r[c] < step) ? 9'h000 : aofs_r[c] - step;

		always_ff @(posedge CORE_CLK) begin
			if (!NRST) begin
				aofs_r[c] <= AOFS_RST;
				mode_r[c] <= BLC_COARSE;
			end else if (CE) begin
				if (fixed_enter) begin
					if (pend_v_r[c] || ofs_wr) begin
						aofs_r[c] <= ofs_wr ? PWDATA[8:0] : pend_r[c];
					end
				end else if (ctrl_r[CTRL_FIXED] && ofs_wr) begin
					aofs_r[c] <= PWDATA[8:0];
				end else if (blc_evt[c]) begin
					if (blc_avg[c] < thr_lo_r) begin
						aofs_r[c] <= up;
					end else if (blc_avg[c] > thr_hi_r) begin
						aofs_r[c] <= dn;
					end else begin
						mode_r[c] <= BLC_FINE;
					end
				end
				if (gain_chg[c]) begin
					mode_r[c] <= BLC_COARSE;
				end
			end
		end

		// a write in automatic mode waits here for the next fixed entry
		always_ff @(posedge CORE_CLK) begin
			if (!NRST) begin
				pend_r[c]   <= AOFS_RST;
				pend_v_r[c] <= 1'b0;
			end else if (CE) begin
				if (ofs_wr) begin
					pend_r[c] <= PWDATA[8:0];
				end
				// a fixed-mode write already acted, so it must not replay later
				pend_v_r[c] <= (ofs_wr && !ctrl_r[CTRL_FIXED]) ||
					(pend_v_r[c] && !fixed_enter);
			end
		end

		always_ff @(posedge CORE_CLK) begin
			if (!NRST) begin
				ANA_GAIN_X8[c] <= 7'h00;
				ANA_OFFSET[c]  <= AOFS_RST;
			end else if (CE) begin
				ANA_GAIN_X8[c] <= agx8[c];
				ANA_OFFSET[c]  <= eff[c];
			end
		end

		// row black: mean of the first eight digitally gained shielded pixels per colour
		assign dk_take = dk2_r && col2_r == pgbl_col_e'(c) && !dfull_r;
		assign dsum_nx = dsum_r + {3'h0, g2_r};
		assign rbl_we[c] = dk_take && dcnt_r == DARK_CNT_LAST;
		assign rbl_wd[c] = (|dsum_nx[19:15]) ? PIX_MAX : dsum_nx[14:3];

		always_ff @(posedge CORE_CLK) begin
			if (!NRST) begin
				dsum_r  <= 20'h00000;
				dcnt_r  <= 3'h0;
				dfull_r <= 1'b0;
			end else if (CE) begin
				if (rs2_r) begin
					dsum_r  <= 20'h00000;
					dcnt_r  <= 3'h0;
					dfull_r <= 1'b0;
				end else if (dk_take) begin
					dsum_r  <= dsum_nx;
					dcnt_r  <= dcnt_r + 3'h1;
					dfull_r <= dcnt_r == DARK_CNT_LAST;
				end
			end
		end
	end

	pgbl_rbl_mem u_rbl (
		.clk     (CORE_CLK),
		.rst_n   (NRST),
		.ce      (CE),
		.we      (rbl_we),
		.wdata   (rbl_wd),
		.raddr_a (col1_r),
		.rdata_a (rbl_a),
		.raddr_b (PADDR[3:2]),
		.rdata_b (rbl_b)
	);

	////////////////////////////////////////////////////////////////////
	// bayer position; frame start primes the row parity to odd, so the first row is even
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			row_par_r <= 1'b0;
			col_par_r <= 1'b0;
		end else if (CE) begin
			if (PIX_FRAME_START) begin
				row_par_r <= 1'b1;
				col_par_r <= 1'b0;
			end else if (PIX_ROW_START) begin
				row_par_r <= ~row_par_r;
				col_par_r <= 1'b0;
			end else if (PIX_VALID) begin
				col_par_r <= ~col_par_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// three stage pixel pipe: capture, digital gain, offsets and clamp
	assign prod = {8'h00, pix1_r} *
		{12'h000, DIG_UNITY + {1'b0, dig_r[col1_r]}};
	assign corr = ctrl_r[CTRL_ROWC] ?
		{2'b00, row_tgt_r} - {2'b00, rbl_a}
		: {{4{row_def_r[9]}}, row_def_r};
	assign sum = {2'b00, g2_r} + {{9{dig_ofs_r[9]}}, dig_ofs_r} +
		{{5{corr[13]}}, corr};

	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			act1_r  <= 1'b0;
			dk1_r   <= 1'b0;
			drow1_r <= 1'b0;
			rs1_r   <= 1'b0;
			pix1_r  <= 12'h000;
			col1_r  <= COL_G1;
			act2_r  <= 1'b0;
			dk2_r   <= 1'b0;
			rs2_r   <= 1'b0;
			col2_r  <= COL_G1;
			g2_r    <= 17'h00000;
		end else if (CE) begin
			act1_r  <= PIX_VALID & ~PIX_DARK_COL;
			dk1_r   <= PIX_VALID & PIX_DARK_COL;
			drow1_r <= PIX_DARK_ROW;
			rs1_r   <= PIX_ROW_START;
			pix1_r  <= PIX_DATA;
			col1_r  <= pgbl_col_e'({row_par_r, col_par_r});
			act2_r  <= act1_r;
			dk2_r   <= dk1_r;
			rs2_r   <= rs1_r;
			col2_r  <= col1_r;
			g2_r    <= prod[19:3];
		end
	end

	// result may go negative or past full scale after the offsets
	always_ff @(posedge CORE_CLK) begin
		if (!NRST) begin
			dout_r <= 12'h000;
			dvld_r <= 1'b0;
		end else if (CE) begin
			dvld_r <= act2_r;
			if (act2_r) begin
				if (sum[18]) begin
					dout_r <= 12'h000;
				end else if (|sum[17:12]) begin
					dout_r <= PIX_MAX;
				end else begin
					dout_r <= sum[11:0];
				end
			end
		end
	end

	assign DOUT       = dout_r;
	assign DOUT_VALID = dvld_r;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);

	chk_pix_latency: assert property (
		(CE && PIX_VALID && !PIX_DARK_COL) ##1 CE [*2] |=> DOUT_VALID)
		else $error("active pixel not output after three cycles");
	chk_clamp_high: assert property (
		(CE && act2_r && !sum[18] && |sum[17:12]) |=> DOUT == PIX_MAX)
		else $error("overflow not clamped to full scale");
	chk_clamp_low: assert property (
		(CE && act2_r && sum[18]) |=> DOUT == 12'h000)
		else $error("negative result not clamped to zero");
	chk_fixed_hold: assert property (
		(CE && ctrl_r[CTRL_FIXED] && !(apb_wr && in_aofs) &&
		!gain_chg[COL_R])
		|=> $stable(aofs_r[COL_R]) && $stable(mode_r[COL_R]))
		else $error("offset moved in fixed mode");
	chk_fixed_write: assert property (
		(CE && ctrl_r[CTRL_FIXED] && apb_wr && in_aofs && PADDR[3:2] == 2'h0)
		|=> aofs_r[COL_G1] == $past(PWDATA[8:0]))
		else $error("fixed mode write not applied");
	chk_green_lock: assert property (
		(CE && ctrl_r[CTRL_LOCK_G] && eq_g) |=> ANA_OFFSET[COL_G2] ==
		$past(aofs_r[COL_G1]))
		else $error("green lock not honoured");
	chk_rb_lock: assert property (
		(CE && ctrl_r[CTRL_LOCK_RB] && eq_rb) |=> ANA_OFFSET[COL_B] ==
		$past(aofs_r[COL_R]))
		else $error("red blue lock not honoured");
	chk_coarse_gain: assert property (
		(CE && gain_chg[COL_G1]) |=> mode_r[COL_G1] == BLC_COARSE)
		else $error("gain change did not restart coarse steps");
	chk_adjust_up: assert property (
		(CE && blc_evt[COL_G1] && blc_avg[COL_G1] < thr_lo_r && !apb_wr &&
		aofs_r[COL_G1] != AOFS_MAX) |=> aofs_r[COL_G1] > $past(aofs_r[COL_G1]))
		else $error("low black level did not raise offset");

	cov_pixel_out: cover property (DOUT_VALID && DOUT != 12'h000);
	cov_fixed_entry: cover property (CE && fixed_enter);
	cov_blc_sample: cover property (CE && blc_evt[COL_R]);
	cov_rbl_update: cover property (CE && |rbl_we);
endmodule // pgbl_core

// *** core/pgbl_pkg.sv ***
package pgbl_pkg;
	localparam int unsigned PIX_W = 12;
	localparam logic [11:0] PIX_MAX = 12'hfff;
	// register byte offsets, per-colour groups step by one word
	localparam logic [11:0] OFS_CTRL    = 12'h000;
	localparam logic [11:0] OFS_THR     = 12'h004;
	localparam logic [11:0] OFS_ROW_TGT = 12'h008;
	localparam logic [11:0] OFS_ROW_DEF = 12'h00c;
	localparam logic [11:0] OFS_DIG_OFS = 12'h010;
	localparam logic [11:0] OFS_GAIN    = 12'h020;
	localparam logic [11:0] OFS_AOFS    = 12'h030;
	localparam logic [11:0] OFS_RBL     = 12'h040;
	// field positions
	localparam int CTRL_FIXED   = 0;
	localparam int CTRL_ROWC    = 1;
	localparam int CTRL_LOCK_G  = 2;
	localparam int CTRL_LOCK_RB = 3;
	localparam int THR_HI_LSB   = 16;
	localparam int GAIN_DBL_BIT = 6;
	localparam int GAIN_DIG_LSB = 8;
	localparam int GAIN_TOT_LSB = 16;
	// reset values
	localparam logic [3:0]  CTRL_RST     = 4'h2;
	localparam logic [11:0] THR_LO_RST   = 12'h0a0;
	localparam logic [11:0] THR_HI_RST   = 12'h0c0;
	localparam logic [11:0] ROW_TGT_RST  = 12'h0a8;
	localparam logic [9:0]  ROW_DEF_RST  = 10'h000;
	localparam logic [9:0]  DIG_OFS_RST  = 10'h000;
	localparam logic [5:0]  ANA_CODE_RST = 6'h08;
	localparam logic [6:0]  DIG_CODE_RST = 7'h00;
	localparam logic [8:0]  AOFS_RST     = 9'h000;
	localparam logic [11:0] RBL_RST      = 12'h000;
	// calibration counts
	localparam logic [4:0]  BLC_CNT_FULL  = 5'h10;
	localparam logic [2:0]  DARK_CNT_LAST = 3'h7;
	localparam logic [8:0]  STEP_COARSE   = 9'h010;
	localparam logic [8:0]  STEP_FINE     = 9'h001;
	localparam logic [8:0]  AOFS_MAX      = 9'h1ff;
	localparam logic [7:0]  DIG_UNITY     = 8'h08;

	typedef enum logic [1:0] {
		COL_G1 = 2'b00,
		COL_R  = 2'b01,
		COL_B  = 2'b10,
		COL_G2 = 2'b11
	} pgbl_col_e;

	typedef enum logic {
		BLC_COARSE = 1'b0,
		BLC_FINE   = 1'b1
	} pgbl_blc_e;
endpackage

// *** core/pgbl_rbl_mem.sv ***
module pgbl_rbl_mem
	import pgbl_pkg::*;
(
	// clock, reset, enable
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	// per-entry write
	input  wire logic [3:0]       we,
	input  wire logic [3:0][11:0] wdata,
	// two registered read ports
	input  wire logic [1:0]       raddr_a,
	output logic      [11:0]      rdata_a,
	input  wire logic [1:0]       raddr_b,
	output logic      [11:0]      rdata_b
);
	logic [11:0] mem_r [4];

	for (genvar i = 0; i < 4; i++) begin : g_ent
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				mem_r[i] <= RBL_RST;
			end else if (ce && we[i]) begin
				mem_r[i] <= wdata[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_a <= RBL_RST;
			rdata_b <= RBL_RST;
		end else if (ce) begin
			rdata_a <= mem_r[raddr_a];
			rdata_b <= mem_r[raddr_b];
		end
	end
endmodule // pgbl_rbl_mem

// *** dv/pgbl_host_model.sv ***
module pgbl_host_model (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// pixel stream from the block
	input wire logic [11:0] dout,
	input wire logic        dout_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	// host keeps pixels in arrival order; the stream has no back-pressure,
	// so a slow host would lose pixels rather than stall the sensor
	logic [11:0] got [$];
	always @(posedge clk) begin
		if (rst_n && dout_valid) begin
			got.push_back(dout);
		end
	end
endmodule // pgbl_host_model

// *** dv/pixel_gain_black_level_path_tb.sv ***
module pixel_gain_black_level_path_tb import pgbl_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic            CORE_CLK, NRST, CE, PSEL, PENABLE, PWRITE;
	logic [11:0]     PADDR, PIX_DATA, DOUT;
	logic [31:0]     PWDATA, PRDATA;
	logic            PREADY, PSLVERR, PIX_VALID, PIX_FRAME_START;
	logic            PIX_ROW_START, PIX_DARK_ROW, PIX_DARK_COL, DOUT_VALID;
	logic [3:0][6:0] ANA_GAIN_X8;
	logic [3:0][8:0] ANA_OFFSET;
	logic [11:0]     exq [$];
	int              errors, compares, dofs, def;
	int              dg [4];
	int              rb [4];
	bit              rowc;
	////////////////////////////////////////
	initial begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end
	pgbl_core dut (.CORE_CLK(CORE_CLK), .NRST(NRST), .CE(CE), .PSEL(PSEL),
		.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
		.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.PIX_VALID(PIX_VALID), .PIX_DATA(PIX_DATA),
		.PIX_FRAME_START(PIX_FRAME_START), .PIX_ROW_START(PIX_ROW_START),
		.PIX_DARK_ROW(PIX_DARK_ROW), .PIX_DARK_COL(PIX_DARK_COL),
		.DOUT(DOUT), .DOUT_VALID(DOUT_VALID), .ANA_GAIN_X8(ANA_GAIN_X8),
		.ANA_OFFSET(ANA_OFFSET));
	pgbl_host_model host (.clk(CORE_CLK), .rst_n(NRST), .dout(DOUT),
		.dout_valid(DOUT_VALID));
	////////////////////////////////////////
	task summarize;
		$display("counts: %0d compares, %0d errors", compares, errors);
		if (errors == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge CORE_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		n = 0;
		do begin
			@(posedge CORE_CLK);
			n++;
		end while (PREADY !== 1'b1 && n < 20);
		if (PREADY !== 1'b1) begin
			errors++;
			summarize();
		end
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] v;
		logic        e;
		apb(1'b1, a, d, v, e);
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] x);
		logic [31:0] v;
		logic        e;
		apb(1'b0, a, 32'h0, v, e);
		chk(v, x);
	endtask
	////////////////////////////////////////
	task pulse(input logic fs);
		@(posedge CORE_CLK);
		PIX_FRAME_START <= fs;
		PIX_ROW_START <= ~fs;
		@(posedge CORE_CLK);
		PIX_FRAME_START <= 1'b0;
		PIX_ROW_START <= 1'b0;
		@(posedge CORE_CLK);
	endtask
	task send(input logic [11:0] d, input logic dr, input logic dc);
		@(posedge CORE_CLK);
		PIX_VALID <= 1'b1;
		PIX_DATA <= d;
		PIX_DARK_ROW <= dr;
		PIX_DARK_COL <= dc;
		@(posedge CORE_CLK);
		PIX_VALID <= 1'b0;
	endtask
	// expected pixel: gain, digital offset, row or default correction, clamp
	function automatic logic [11:0] ex(input int p, input int c);
		int v;
		v = p * (8 + dg[c]) / 8 + dofs;
		v = v + (rowc ? int'(ROW_TGT_RST) - rb[c] : def);
		v = v < 0 ? 0 : (v > 4095 ? 4095 : v);
		return v[11:0];
	endfunction
	task act(input logic [11:0] p, input int c);
		send(p, 1'b0, 1'b0);
		exq.push_back(ex(int'(p), c));
	endtask
	task drain;
		repeat (5) @(posedge CORE_CLK);
		chk(32'(host.got.size()), 32'(exq.size()));
		foreach (exq[i]) chk(32'(host.got[i]), 32'(exq[i]));
		host.got.delete();
		exq.delete();
	endtask
	// one dark-row frame of raw samples, closed by the next frame start
	task calib(input logic [11:0] v);
		pulse(1'b1);
		pulse(1'b0);
		repeat (32) send(v, 1'b1, 1'b0);
		pulse(1'b1);
		// let the offset outputs and the last dark pixel settle first
		repeat (2) @(posedge CORE_CLK);
		host.got.delete();
	endtask
	////////////////////////////////////////
	task t_reset;
		logic [31:0] v;
		logic        e;
		for (int c = 0; c < 4; c++) begin
			rdc(OFS_AOFS + 12'(4 * c), 32'h0);
			chk(32'(ANA_GAIN_X8[c]), 32'h8);
			chk(32'(ANA_OFFSET[c]), 32'h0);
		end
		rdc(OFS_THR, 32'h00c000a0);
		rdc(OFS_CTRL, 32'h2);
		apb(1'b0, 12'h050, 32'h0, v, e);
		chk(v, 32'h0);
		chk(32'(e), 32'h1);
		// clock enable low in the access phase stalls the answer
		fork
			wr(OFS_ROW_DEF, 32'h5);
			begin
				repeat (2) @(posedge CORE_CLK);
				CE <= 1'b0;
				repeat (3) @(posedge CORE_CLK);
				CE <= 1'b1;
			end
		join
		rdc(OFS_ROW_DEF, 32'h5);
		$display("test reset done");
	endtask
	task t_calib;
		calib(12'h010);
		chk(32'(ANA_OFFSET[0]), 32'h10);
		chk(32'(ANA_OFFSET[2]), 32'h0);
		calib(12'h0b0);
		chk(32'(ANA_OFFSET[1]), 32'h10);
		// gain code kept in 1..4 with the doubler on
		wr(OFS_GAIN, 32'h43);
		repeat (2) @(posedge CORE_CLK);
		chk(32'(ANA_GAIN_X8[0]), 32'h6);
		calib(12'h010);
		chk(32'(ANA_OFFSET[0]), 32'h20);
		chk(32'(ANA_OFFSET[1]), 32'h11);
		wr(OFS_CTRL, 32'h3);
		calib(12'h010);
		chk(32'(ANA_OFFSET[0]), 32'h20);
		$display("test calib done");
	endtask
	task t_fixed;
		wr(OFS_CTRL, 32'h2);
		wr(OFS_AOFS + 12'h00c, 32'h44);
		rdc(OFS_AOFS + 12'h00c, 32'h0);
		wr(OFS_CTRL, 32'h3);
		rdc(OFS_AOFS + 12'h00c, 32'h44);
		wr(OFS_AOFS + 12'h008, 32'h33);
		repeat (2) @(posedge CORE_CLK);
		chk(32'(ANA_OFFSET[2]), 32'h33);
		wr(OFS_CTRL, 32'hb);
		rdc(OFS_AOFS + 12'h008, 32'h11);
		chk(32'(ANA_OFFSET[2]), 32'h11);
		wr(OFS_CTRL, 32'hf);
		rdc(OFS_AOFS + 12'h00c, 32'h44);
		wr(OFS_GAIN, 32'h8);
		rdc(OFS_AOFS + 12'h00c, 32'h20);
		$display("test fixed done");
	endtask
	// reset target keeps saturated pixels saturated for these gains
	task t_rowc;
		wr(OFS_CTRL, 32'h2);
		rowc = 1'b1;
		dg = '{0, 8, 4, 1};
		for (int c = 0; c < 4; c++) begin
			rb[c] = 64 * (8 + dg[c]) / 8;
			wr(OFS_GAIN + 12'(4 * c), 32'(dg[c] * 256 + 8));
		end
		pulse(1'b1);
		pulse(1'b0);
		repeat (16) send(12'h040, 1'b0, 1'b1);
		act(12'h100, 0);
		act(12'h200, 1);
		act(12'hff0, 0);
		act(12'h001, 1);
		pulse(1'b0);
		repeat (16) send(12'h040, 1'b0, 1'b1);
		act(12'h123, 2);
		act(12'h321, 3);
		drain();
		for (int c = 0; c < 4; c++) begin
			rdc(OFS_RBL + 12'(4 * c), 32'(rb[c]));
		end
		// red: analog 1.0 times digital 2.0 is 128 sixty-fourths
		rdc(OFS_GAIN + 12'h004, 32'h00800808);
		$display("test row correction done");
	endtask
	// first pass: default offset is target minus a dark level of 0x40
	task t_rowoff;
		wr(OFS_CTRL, 32'h0);
		rowc = 1'b0;
		for (int k = 0; k < 2; k++) begin
			def = k ? -300 : 104;
			dofs = k ? -512 : 511;
			wr(OFS_ROW_DEF, 32'(10'(def)));
			wr(OFS_DIG_OFS, 32'(10'(dofs)));
			pulse(1'b1);
			pulse(1'b0);
			act(12'h100, 0);
			act(12'he00, 1);
			act(12'h050, 0);
			pulse(1'b0);
			act(12'h7ff, 2);
			act(12'h000, 3);
			drain();
		end
		$display("test default offset done");
	endtask
	////////////////////////////////////////
	initial begin
		{NRST, PSEL, PENABLE, PWRITE, PIX_VALID, PIX_FRAME_START} = '0;
		{PIX_ROW_START, PIX_DARK_ROW, PIX_DARK_COL, rowc} = '0;
		{PADDR, PIX_DATA, PWDATA, errors, compares, dofs, def} = '0;
		CE = 1'b1;
		repeat (3) @(posedge CORE_CLK);
		NRST <= 1'b1;
		t_reset();
		t_calib();
		t_fixed();
		t_rowc();
		t_rowoff();
		summarize();
	end
endmodule // pixel_gain_black_level_path_tb
